// file: src/ics_target.sv
// channel select target: serial command decoder and switch enables
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - A write address (direction bit 0) that matches is acknowledged.
// - The byte after a write address loads the control byte, bits 0-2 pick channels.
// - Bits 7 to 3 of a written control byte are discarded.
// - Any number of write bytes is taken; only the last before STOP is kept.
// - A new selection reaches the switches only at the following STOP.
// - A read address (direction bit 1) that matches is acknowledged.
// - Each read byte that the controller acks is followed by the byte again; a nack ends it.
// - A read returns any number of control bytes.
// - Read bits 0-2 show the channels applied at the latest STOP.
// - Reset clears the control byte and the serial state, deselecting all channels.
module ics_target #(
  parameter logic [ics_pkg::ADDR_W-1:0] DEV_ADDR = ics_pkg::DEV_ADDR_DEF
) (
  input wire logic sys_clk_i, // core clock
  input wire logic rstn_i, // sync reset, low active
  input wire logic scl_i, // serial clock, link domain
  input wire logic sda_i, // serial data from the line
  output logic sda_o, // serial data out, held low
  output logic sda_oe_o, // high pulls the data line low
  output logic [ics_pkg::CHAN_W-1:0] chan_en_o, // channel switch enables
  output logic busy_o // target engaged: from start until stop, nack or a foreign address
);
  import ics_pkg::*;

  // link domain: bit taken at each serial clock rise
  logic link_bit;

  always_ff @(posedge scl_i) begin
    link_bit <= sda_i;
  end

  // core domain: line synchronisers
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // line events
  wire start_ev = scl_s && scl_d && sda_d && !sda_s;
  wire stop_ev = scl_s && scl_d && !sda_d && sda_s;
  // link_bit is settled well before the synced rise shows
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;

  ics_state_t state;
  ics_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [BYTE_W-1:0] shreg;
  logic [BYTE_W-1:0] next_shreg;
  logic [BYTE_W-1:0] tx;
  logic [BYTE_W-1:0] next_tx;
  logic ack_seen;
  logic next_ack;
  logic mack;
  logic next_mack;
  logic rw;
  logic next_rw;
  logic [CHAN_W-1:0] pend;
  logic [CHAN_W-1:0] next_pend;
  logic pend_valid;
  logic next_pvld;
  logic [CHAN_W-1:0] next_chan;
  logic next_drv;

  wire [BYTE_W-1:0] rx_byte = {shreg[BYTE_W-2:0], link_bit};
  wire [BYTE_W-1:0] rd_byte = {HI_ZERO, chan_en_o};
  wire last_in = scl_rise && (cnt == LAST_BIT);
  wire addr_hit = rx_byte[BYTE_W-1:1] == DEV_ADDR;
  wire ack_done = scl_fall && ack_seen;
  wire ack_drive = scl_fall && !ack_seen;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_tx = tx;
    next_ack = ack_seen;
    next_mack = mack;
    next_rw = rw;
    next_pend = pend;
    next_pvld = pend_valid;
    next_chan = chan_en_o;
    next_drv = sda_oe_o;
    if (stop_ev) begin
      next_state = ST_IDLE;
      next_drv = 1'b0;
      next_pvld = 1'b0;
      if (pend_valid) begin
        next_chan = pend;
      end
    end else if (start_ev) begin
      next_state = ST_ADDR;
      next_cnt = CNT_ZERO;
      next_drv = 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_cnt = cnt + CNT_STEP;
          end
          if (last_in && addr_hit) begin
            next_state = ST_AACK;
            next_rw = link_bit;
            next_ack = 1'b0;
          end else if (last_in) begin
            next_state = ST_IDLE;
          end
        end
        ST_AACK: begin
          if (scl_rise) begin
            next_ack = 1'b1;
          end else if (ack_drive) begin
            next_drv = 1'b1;
          end else if (ack_done && rw == RW_READ) begin
            next_state = ST_RD;
            next_cnt = CNT_ZERO;
            next_tx = {rd_byte[BYTE_W-2:0], 1'b0};
            next_drv = !rd_byte[BYTE_W-1];
          end else if (ack_done) begin
            next_state = ST_WR;
            next_cnt = CNT_ZERO;
            next_drv = 1'b0;
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_cnt = cnt + CNT_STEP;
          end
          if (last_in) begin
            next_pend = rx_byte[CHAN_W-1:0];
            next_pvld = 1'b1;
            next_state = ST_WACK;
            next_ack = 1'b0;
          end
        end
        ST_WACK: begin
          if (scl_rise) begin
            next_ack = 1'b1;
          end else if (ack_drive) begin
            next_drv = 1'b1;
          end else if (ack_done) begin
            next_state = ST_WR;
            next_cnt = CNT_ZERO;
            next_drv = 1'b0;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            next_cnt = cnt + CNT_STEP;
          end else if (scl_fall && cnt == BITS_PER_BYTE) begin
            next_state = ST_RACK;
            next_ack = 1'b0;
            next_drv = 1'b0;
          end else if (scl_fall) begin
            next_drv = !tx[BYTE_W-1];
            next_tx = {tx[BYTE_W-2:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_ack = 1'b1;
            next_mack = link_bit == ACK_LVL;
          end else if (ack_done && mack) begin
            next_state = ST_RD;
            next_cnt = CNT_ZERO;
            next_tx = {rd_byte[BYTE_W-2:0], 1'b0};
            next_drv = !rd_byte[BYTE_W-1];
          end else if (ack_done) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      shreg <= BYTE_RST;
      tx <= BYTE_RST;
      ack_seen <= 1'b0;
      mack <= 1'b0;
      rw <= 1'b0;
      pend <= CHAN_RST;
      pend_valid <= 1'b0;
      chan_en_o <= CHAN_RST;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      tx <= next_tx;
      ack_seen <= next_ack;
      mack <= next_mack;
      rw <= next_rw;
      pend <= next_pend;
      pend_valid <= next_pvld;
      chan_en_o <= next_chan;
      sda_oe_o <= next_drv;
      sda_o <= 1'b0;
      busy_o <= next_state != ST_IDLE;
    end
  end

  addr_ack_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_AACK && ack_drive && !start_ev && !stop_ev)
        |=> sda_oe_o && !sda_o)
    else $error("address not acknowledged");

  read_dir_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_AACK && ack_done && rw && !start_ev && !stop_ev)
        |=> state == ST_RD)
    else $error("read address did not start read data");

  last_byte_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_WR && last_in && !start_ev && !stop_ev)
        |=> pend == $past(rx_byte[CHAN_W-1:0]) && pend_valid)
    else $error("written byte not held as pending");

  stop_apply_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (stop_ev && pend_valid) |=> chan_en_o == $past(pend))
    else $error("selection not applied at stop");

  hold_sel_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !stop_ev |=> $stable(chan_en_o))
    else $error("selection changed outside stop");

  nack_end_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_RACK && ack_done && !mack && !start_ev && !stop_ev)
        |=> state == ST_IDLE && !sda_oe_o)
    else $error("read not ended by nack");

  reread_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_RACK && ack_done && mack && !start_ev && !stop_ev)
        |=> state == ST_RD && cnt == CNT_ZERO && sda_oe_o)
    else $error("acked read byte not repeated");

  read_hi_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_RD && scl_fall && cnt < 4'h5 && cnt != CNT_ZERO)
        |=> sda_oe_o)
    else $error("upper read bits not zero");

  read_chan_hi_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_RD && scl_fall && cnt == 4'h5)
        |=> sda_oe_o == !chan_en_o[CHAN_W-1])
    else $error("read bit 2 not the applied channel");

  read_chan_lo_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_RD && scl_fall && cnt == LAST_BIT)
        |=> sda_oe_o == !chan_en_o[0])
    else $error("read bit 0 not the applied channel");

  idle_quiet_a:
    assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state == ST_IDLE && !start_ev)
        |=> !sda_oe_o)
    else $error("data line driven while idle");

  reset_clr_a:
    assert property (@(posedge sys_clk_i)
      !rstn_i |=> chan_en_o == CHAN_RST && state == ST_IDLE && !sda_oe_o)
    else $error("reset did not clear state");

endmodule : ics_target

`default_nettype wire

// file: src/ics_pkg.sv
// package: constants and state codes of the channel select target
package ics_pkg;

  localparam int CHAN_W = 3;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;

  // bit counter values
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // bus levels and direction bit
  localparam logic RW_READ = 1'b1;
  localparam logic ACK_LVL = 1'b0;

  // control byte layout
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [BYTE_W-CHAN_W-1:0] HI_ZERO = 5'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // arbitrary value, set per board
  localparam logic [ADDR_W-1:0] DEV_ADDR_DEF = 7'h5a;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR = 7'h08,
    ST_WACK = 7'h10,
    ST_RD = 7'h20,
    ST_RACK = 7'h40
  } ics_state_t;

endpackage : ics_pkg

// file: verif/ics_ctrl_model.sv
// upstream serial controller model, paced by the link clock
`timescale 1ns/1ns
`default_nettype none
module ics_ctrl_model (
  input wire logic link_clk_i, // pacing clock
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock, stands high outside frames
  output logic sda_oe_o // high pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic wait_lc(input int n);
    repeat (n) @(posedge link_clk_i);
    #1;
  endtask : wait_lc
  // also serves as repeated start from a low clock
  task automatic start_c;
    sda_oe_o = 1'b0;
    wait_lc(4);
    scl_o = 1'b1;
    wait_lc(5);
    sda_oe_o = 1'b1;
    wait_lc(5);
    scl_o = 1'b0;
  endtask : start_c
  task automatic stop_c;
    wait_lc(3);
    sda_oe_o = 1'b1;
    wait_lc(5);
    scl_o = 1'b1;
    wait_lc(5);
    sda_oe_o = 1'b0;
    wait_lc(5);
  endtask : stop_c
  // data set mid low phase, sampled mid high phase
  task automatic bit_c(input logic b, output logic seen);
    wait_lc(3);
    sda_oe_o = ~b;
    wait_lc(5);
    scl_o = 1'b1;
    wait_lc(3);
    seen = sda_i;
    wait_lc(3);
    scl_o = 1'b0;
  endtask : bit_c
  // address lsb carries direction; ack_in low acks a read byte
  task automatic byte_c(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack_seen);
    for (int i = 7; i >= 0; i--) bit_c(tx[i], rx[i]);
    bit_c(ack_in, ack_seen);
  endtask : byte_c
endmodule : ics_ctrl_model
`default_nettype wire

// file: verif/tb_ics_target.sv
// testbench of the channel select target
`timescale 1ns/1ns
`default_nettype none
module tb_ics_target;
  import ics_pkg::*;
  localparam logic [7:0] WADR = {DEV_ADDR_DEF, 1'b0};
  localparam logic [7:0] RADR = {DEV_ADDR_DEF, 1'b1};
  logic sys_clk_i = 1'b0;
  logic lclk = 1'b1;
  logic rstn_i = 1'b0;
  wire logic scl;
  wire logic sda;
  wire logic m_oe;
  wire logic sda_o;
  wire logic sda_oe;
  wire logic busy;
  wire logic [CHAN_W-1:0] chan;
  logic [7:0] rx;
  logic a;
  int error_cnt = 0;
  int cmp_count = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  always #24 lclk = ~lclk;
  // pulled-up open-drain data line
  assign sda = ~(m_oe | (sda_oe & ~sda_o));
  ics_target uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .chan_en_o(chan), .busy_o(busy));
  ics_ctrl_model ctl (.link_clk_i(lclk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] d);
    ctl.byte_c(d, 1'b1, rx, a);
    check({7'h00, a}, {7'h00, ACK_LVL});
  endtask : wr
  task automatic rd(input logic nack, input logic [7:0] exp);
    ctl.byte_c(8'hff, nack, rx, a);
    check(rx, exp);
  endtask : rd
  task automatic reset_dut;
    @(posedge sys_clk_i);
    #1 rstn_i = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check({4'h0, busy, chan}, 8'h00);
  endtask : reset_dut
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    #500000;
    error_cnt++;
    results();
  end
  initial begin
    reset_dut();
    ctl.start_c();
    wr(WADR);
    check({7'h00, busy}, 8'h01);
    wr(8'hfd);
    check({5'h00, chan}, 8'h00);
    ctl.stop_c();
    check({4'h0, busy, chan}, 8'h05);
    $display("test single write done");
    ctl.start_c();
    wr(WADR);
    wr(8'h02);
    wr(8'h06);
    check({5'h00, chan}, 8'h05);
    ctl.stop_c();
    check({5'h00, chan}, 8'h06);
    $display("test multi write done");
    ctl.start_c();
    wr(RADR);
    for (int i = 0; i < 3; i++) rd(i == 2, 8'h06);
    ctl.wait_lc(4);
    check({7'h00, sda_oe}, 8'h00);
    ctl.stop_c();
    $display("test read done");
    ctl.start_c();
    ctl.byte_c({DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, rx, a);
    check({7'h00, a}, 8'h01);
    ctl.byte_c(8'h07, 1'b1, rx, a);
    check({7'h00, busy}, 8'h00);
    ctl.stop_c();
    check({5'h00, chan}, 8'h06);
    $display("test foreign address done");
    ctl.start_c();
    wr(WADR);
    wr(8'hab);
    ctl.start_c();
    wr(RADR);
    rd(1'b1, 8'h06);
    ctl.stop_c();
    check({5'h00, chan}, 8'h03);
    $display("test repeated start done");
    reset_dut();
    ctl.start_c();
    wr(RADR);
    rd(1'b1, 8'h00);
    ctl.stop_c();
    $display("test second reset done");
    results();
  end
endmodule : tb_ics_target
`default_nettype wire
